// ---- design/cith_pkg.sv ----
// Purpose: Shared constants and types for the chemical inject timer hold
// Assumes: 40 MHz clock, one-cycle second tick derived inside the block
// Notes: Times are held in their own units and converted to cycles here
package cith_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CHEM_NUM = 5;
  localparam int unsigned TIME_W = 16;
  localparam int unsigned DEB_MS = 10;
  localparam int unsigned DEB_CYC = (CLK_HZ / 1000) * DEB_MS;
  localparam int unsigned SEC_CYC = CLK_HZ;
  localparam int unsigned MIN_INJ_S = 10;
  localparam logic [15:0] FLUSH_S_RST = 16'h0005;

  typedef enum logic [4:0] {
    CITH_IDLE = 5'h01,
    CITH_RUN = 5'h02,
    CITH_FLUSH_WAIT = 5'h04,
    CITH_FLUSH = 5'h08,
    CITH_DONE = 5'h10
  } cith_state_type;
endpackage

// ---- design/cith_tick_if.sv ----
// Purpose: Carries the hold level and second tick between block modules
// Assumes: Single clock domain
// Notes: Filter drives hold, main block consumes it
`timescale 1ns/1ps
interface cith_tick_if;
  logic hold;
  logic tick;
  modport src (output hold, output tick);
  modport dst (input hold, input tick);
endinterface

// ---- design/cith_stop_filter.sv ----
// Purpose: Synchronise and debounce timer stop contact, make second tick
// Assumes: Contact closed reads as stop_n low
// Notes: Hold changes only after input stable for the debounce count
`timescale 1ns/1ps
module cith_stop_filter #(
  parameter int unsigned DEB_CYC = cith_pkg::DEB_CYC,
  parameter int unsigned SEC_CYC = cith_pkg::SEC_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic timer_stop_n,
  cith_tick_if.src tk
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic hold;
    logic [31:0] deb;
    logic [31:0] sec;
  } cith_flt_type;
  cith_flt_type r_q, r_d;

  always_comb begin
    r_d = r_q;
    r_d.s1 = ~timer_stop_n;
    r_d.s2 = r_q.s1;
    if (r_q.s2 == r_q.hold) begin
      r_d.deb = 32'h0;
    end else if (r_q.deb >= DEB_CYC - 1) begin
      r_d.deb = 32'h0;
      r_d.hold = r_q.s2;
    end else begin
      r_d.deb = r_q.deb + 32'h1;
    end
    if (r_q.sec >= SEC_CYC - 1) begin
      r_d.sec = 32'h0;
    end else begin
      r_d.sec = r_q.sec + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign tk.hold = r_q.hold;
  assign tk.tick = (r_q.sec == SEC_CYC - 1);

  chk_hold_debounce: assert property (@(posedge clk) disable iff (!resetn)
    (r_q.s2 == r_q.hold) |=> !$changed(r_q.hold))
    else $error("Hold changed without a stable differing input");
endmodule

// ---- design/cith_step.sv ----
// Purpose: Formula step sequencer with chemical, flush and hold handling
// Assumes: Step loaded by start pulse; times in whole seconds
// Notes: Coin mode strap ignores the stop contact entirely
`timescale 1ns/1ps
module cith_step #(
  parameter int unsigned CHEM_NUM = cith_pkg::CHEM_NUM,
  parameter int unsigned TIME_W = cith_pkg::TIME_W,
  parameter int unsigned DEB_CYC = cith_pkg::DEB_CYC,
  parameter int unsigned SEC_CYC = cith_pkg::SEC_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic timer_stop_n,
  input wire logic coin_mode,
  input wire logic step_start,
  input wire logic [TIME_W-1:0] step_time_s,
  input wire logic [CHEM_NUM-1:0] chem_sel,
  input wire logic [TIME_W-1:0] inject_time_s,
  input wire logic [TIME_W-1:0] flush_time_s,
  input wire logic fill_req,
  input wire logic level_reached,
  input wire logic [2:0] motion_req,
  output logic [CHEM_NUM-1:0] chem_req,
  output logic flush_out,
  output logic fill_out,
  output logic [2:0] motion_out,
  output logic [TIME_W-1:0] remain_s,
  output logic timer_held,
  output logic step_busy,
  output logic step_done
);
  typedef struct packed {
    cith_pkg::cith_state_type st;
    logic [TIME_W-1:0] remain;
    logic [TIME_W-1:0] inj;
    logic [TIME_W-1:0] flush;
    logic [TIME_W-1:0] flush_len;
    logic [CHEM_NUM-1:0] sel;
    logic [CHEM_NUM-1:0] chem;
    logic flush_due;
    logic flush_on;
    logic fill;
    logic [2:0] motion;
    logic done;
  } cith_step_type;
  cith_step_type r_q, r_d;

  cith_tick_if tk ();
  logic held;

  cith_stop_filter #(
    .DEB_CYC(DEB_CYC),
    .SEC_CYC(SEC_CYC)
  ) u_filter (
    .clk(clk),
    .resetn(resetn),
    .timer_stop_n(timer_stop_n),
    .tk(tk)
  );

  assign held = tk.hold & ~coin_mode;

  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    case (r_q.st)
      cith_pkg::CITH_IDLE, cith_pkg::CITH_DONE: begin
        if (step_start) begin
          r_d.st = cith_pkg::CITH_RUN;
          r_d.remain = step_time_s;
          r_d.inj = inject_time_s;
          r_d.flush_len = flush_time_s;
          r_d.sel = chem_sel;
          r_d.chem = (inject_time_s != '0) ? chem_sel : '0;
          r_d.flush_due = 1'b0;
          r_d.fill = fill_req;
          r_d.motion = motion_req;
        end
      end
      cith_pkg::CITH_RUN, cith_pkg::CITH_FLUSH_WAIT,
      cith_pkg::CITH_FLUSH: begin
        if (r_q.fill && level_reached) begin
          r_d.fill = 1'b0;
        end
        if (tk.tick) begin
          if (r_q.chem != '0) begin
            if (r_q.inj <= 1) begin
              r_d.chem = '0;
              r_d.flush_due = 1'b1;
            end else begin
              r_d.inj = r_q.inj - 1'b1;
            end
          end
          if (!held && r_q.remain != '0) begin
            r_d.remain = r_q.remain - 1'b1;
          end
          if (r_q.flush_on) begin
            if (r_q.flush <= 1) begin
              r_d.flush_on = 1'b0;
            end else begin
              r_d.flush = r_q.flush - 1'b1;
            end
          end
        end
        if (r_q.flush_due && !held && !r_q.flush_on) begin
          r_d.flush_due = 1'b0;
          r_d.flush_on = 1'b1;
          r_d.flush = (r_q.flush_len == '0) ? TIME_W'(1) : r_q.flush_len;
        end
        if (r_q.flush_due) begin
          r_d.st = cith_pkg::CITH_FLUSH_WAIT;
        end else if (r_q.flush_on) begin
          r_d.st = cith_pkg::CITH_FLUSH;
        end else begin
          r_d.st = cith_pkg::CITH_RUN;
        end
        if (r_q.remain == '0 && !held && r_q.chem == '0 &&
            !r_q.flush_due && !r_q.flush_on) begin
          r_d.st = cith_pkg::CITH_DONE;
          r_d.motion = '0;
          r_d.fill = 1'b0;
          r_d.done = 1'b1;
        end
      end
      default: begin
        r_d = '0;
        r_d.st = cith_pkg::CITH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_q <= '0;
      r_q.st <= cith_pkg::CITH_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  // One request output per chemical channel
  for (genvar i = 0; i < CHEM_NUM; i++) begin
    assign chem_req[i] = r_q.chem[i];
    chk_chan_sel: assert property (@(posedge clk) disable iff (!resetn)
      chem_req[i] |-> r_q.sel[i])
      else $error("Chemical output not selected for this step");
  end
  assign flush_out = r_q.flush_on;
  assign fill_out = r_q.fill;
  assign motion_out = r_q.motion;
  assign remain_s = r_q.remain;
  assign timer_held = held;
  assign step_busy = (r_q.st != cith_pkg::CITH_IDLE) &&
                     (r_q.st != cith_pkg::CITH_DONE);
  assign step_done = r_q.done;

  chk_timer_hold: assert property (@(posedge clk) disable iff (!resetn)
    (held && step_busy && !step_start) |=> $stable(remain_s))
    else $error("Remaining time moved while held");

  chk_timer_resume: assert property (@(posedge clk) disable iff (!resetn)
    (!held && tk.tick && step_busy && remain_s != '0)
    |=> remain_s == $past(remain_s) - 1'b1)
    else $error("Timer did not resume decrement");

  chk_no_advance: assert property (@(posedge clk) disable iff (!resetn)
    (held && step_busy) |=> !step_done)
    else $error("Event ended while held");

  chk_fill_close: assert property (@(posedge clk) disable iff (!resetn)
    (fill_out && level_reached) |=> !fill_out)
    else $error("Fill stayed open at level");

  chk_chem_end: assert property (@(posedge clk) disable iff (!resetn)
    (chem_req != '0 && tk.tick && r_q.inj <= 1 && step_busy)
    |=> chem_req == '0 && r_q.flush_due)
    else $error("Chemical did not end at its time");

  chk_flush_defer: assert property (@(posedge clk) disable iff (!resetn)
    (held && !flush_out) |=> !flush_out)
    else $error("Flush started while held");

  chk_flush_after: assert property (@(posedge clk) disable iff (!resetn)
    (r_q.flush_due && !held && !flush_out) |=> flush_out)
    else $error("Flush not issued after injection");

  chk_motion_hold: assert property (@(posedge clk) disable iff (!resetn)
    (held && step_busy) |=> $stable(motion_out))
    else $error("Motion changed while held");

  chk_coin_ignore: assert property (@(posedge clk) disable iff (!resetn)
    coin_mode |-> !timer_held)
    else $error("Hold active in coin mode");

  chk_busy_chem: assert property (@(posedge clk) disable iff (!resetn)
    (chem_req != '0)
    |-> step_busy)
    else $error("Chemical requested outside a step");

  chk_flush_busy: assert property (@(posedge clk) disable iff (!resetn)
    flush_out
    |-> step_busy)
    else $error("Flush active outside a step");

  chk_flush_nochem: assert property (@(posedge clk) disable iff (!resetn)
    flush_out
    |-> chem_req == '0)
    else $error("Flush overlaps an injection");

  chk_done_pulse: assert property (@(posedge clk) disable iff (!resetn)
    step_done
    |=> !step_done)
    else $error("Done longer than one cycle");

  chk_done_busy: assert property (@(posedge clk) disable iff (!resetn)
    step_done
    |-> !step_busy)
    else $error("Done while still busy");

  chk_done_clear: assert property (@(posedge clk) disable iff (!resetn)
    step_done
    |-> remain_s == '0 && motion_out == '0 && !fill_out)
    else $error("Step ended with actions still on");

  chk_start_load: assert property (@(posedge clk) disable iff (!resetn)
    (!step_busy && step_start)
    |=> step_busy && remain_s == $past(step_time_s))
    else $error("Step not loaded on start");

  chk_chem_load: assert property (@(posedge clk) disable iff (!resetn)
    (!step_busy && step_start && inject_time_s != '0)
    |=> chem_req == $past(chem_sel))
    else $error("Chemical outputs differ from selection");

  chk_chem_keep: assert property (@(posedge clk) disable iff (!resetn)
    (held && chem_req != '0 && !(tk.tick && r_q.inj <= 1))
    |=> chem_req == $past(chem_req))
    else $error("Injection cut short by hold");

  chk_fill_keep: assert property (@(posedge clk) disable iff (!resetn)
    (held && fill_out && !level_reached)
    |=> fill_out)
    else $error("Fill closed during hold before level");

  chk_remain_floor: assert property (@(posedge clk) disable iff (!resetn)
    (remain_s == '0 && step_busy)
    |=> remain_s == '0)
    else $error("Remaining time wrapped");

  chk_remain_tick: assert property (@(posedge clk) disable iff (!resetn)
    (!tk.tick && step_busy)
    |=> $stable(remain_s))
    else $error("Remaining time moved without tick");

  chk_flush_end: assert property (@(posedge clk) disable iff (!resetn)
    (flush_out && tk.tick && r_q.flush <= 1)
    |=> !flush_out)
    else $error("Flush outlasted its time");

  chk_idle_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !step_busy
    |-> chem_req == '0 && !flush_out && motion_out == '0)
    else $error("Outputs active while idle");

  chk_fill_idle: assert property (@(posedge clk) disable iff (!resetn)
    !step_busy
    |-> !fill_out)
    else $error("Fill open while idle");

  chk_inj_count: assert property (@(posedge clk) disable iff (!resetn)
    (chem_req != '0 && tk.tick && r_q.inj > 1)
    |=> r_q.inj == $past(r_q.inj) - 1'b1)
    else $error("Injection time not counted");

  chk_coin_count: assert property (@(posedge clk) disable iff (!resetn)
    (coin_mode && tk.tick && step_busy && remain_s != '0)
    |=> remain_s == $past(remain_s) - 1'b1)
    else $error("Timer stopped in coin mode");

  chk_done_unheld: assert property (@(posedge clk) disable iff (!resetn)
    step_done
    |-> !$past(held))
    else $error("Step ended while held");

  chk_flush_source: assert property (@(posedge clk) disable iff (!resetn)
    $rose(flush_out)
    |-> $past(r_q.flush_due))
    else $error("Flush without a pending injection");

  chk_due_keep: assert property (@(posedge clk) disable iff (!resetn)
    (r_q.flush_due && held)
    |=> r_q.flush_due)
    else $error("Pending flush lost during hold");
endmodule

// ---- tb/cith_supply_model.sv ----
// Purpose: Chemical supply partner driving the stop contact
// Assumes: Contact open reads high through a pull-up
// Notes: Slow mode adds lag before the contact follows a request
`timescale 1ns/1ps
module cith_supply_model (
  input wire logic clk,
  input wire logic other_req,
  input wire logic slow,
  output logic timer_stop_n
);
  logic [3:0] lag_q = 4'h0;
  always_ff @(posedge clk) begin
    lag_q <= {lag_q[2:0], other_req};
  end
  // Closed while a linked machine injects, open when it is done
  assign timer_stop_n = ~(slow ? lag_q[3] : lag_q[0]);
endmodule

// ---- tb/chemical_inject_timer_hold_bench.sv ----
// Purpose: Self-checking bench for the step sequencer
// Assumes: Short tick and debounce counts for simulation
// Notes: Inputs change on the falling clock edge
`timescale 1ns/1ps
module chemical_inject_timer_hold_bench;
  logic clk = 0, resetn = 0, stop_n, coin_mode = 0, step_start = 0;
  logic fill_req = 0, level_reached = 0, other_req = 0, slow = 0;
  logic [15:0] step_time_s = 0, inject_time_s = 0, flush_time_s = 1;
  logic [4:0] chem_sel = 0, chem_req;
  logic [2:0] motion_req = 0, motion_out;
  logic [15:0] remain_s, r;
  logic flush_out, fill_out, timer_held, step_busy, step_done;
  int bad_count = 0, comparisons = 0;
  cith_step #(.DEB_CYC(4), .SEC_CYC(10)) cith_step_i (.clk, .resetn,
    .timer_stop_n(stop_n), .coin_mode, .step_start, .step_time_s,
    .chem_sel, .inject_time_s, .flush_time_s, .fill_req, .level_reached,
    .motion_req, .chem_req, .flush_out, .fill_out, .motion_out,
    .remain_s, .timer_held, .step_busy, .step_done);
  cith_supply_model cith_supply_model_i (.clk, .other_req, .slow,
    .timer_stop_n(stop_n));
  initial forever #12.5 clk = ~clk;
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic logic met(input int c);
    case (c)
      0: return chem_req === 5'h00;
      1: return flush_out === 1'b1;
      2: return step_done === 1'b1;
      default: return timer_held === c[0];
    endcase
  endfunction
  // Bounded wait; codes 3 and 4 wait for hold on and off
  task automatic wait_for(input int c, input int lim);
    for (int i = 0; i < lim && !met(c); i++) @(negedge clk);
    if (!met(c)) begin
      bad_count++;
      $display("BAD wait %0d expected met seen timeout", c);
      give_verdict();
    end
  endtask
  task automatic go(input logic [4:0] sel, input logic [15:0] inj, st);
    chem_sel = sel;
    inject_time_s = inj;
    step_time_s = st;
    step_start = 1;
    @(negedge clk);
    step_start = 0;
  endtask
  task automatic t_each;
    for (int k = 0; k < 5; k++) begin
      go(5'h01 << k, 16'h0001, 16'h0002);
      chk("chem", 5'h01 << k, chem_req);
      wait_for(0, 40);
      wait_for(1, 40);
      chk("flush", 1, flush_out);
      wait_for(2, 60);
    end
  endtask
  task automatic t_glitch;
    other_req = 1;
    repeat (2) @(negedge clk);
    other_req = 0;
    repeat (10) @(negedge clk);
    chk("held", 0, timer_held);
  endtask
  task automatic t_hold;
    slow = 1;
    fill_req = 1;
    motion_req = 3'h7;
    go(5'h0a, 16'h000a, 16'h000c);
    other_req = 1;
    wait_for(3, 20);
    r = remain_s;
    repeat (110) @(negedge clk);
    chk("remain", r, remain_s);
    chk("busy", 1, step_busy);
    chk("chem", 0, chem_req);
    chk("flush", 0, flush_out);
    chk("motion", 3'h7, motion_out);
    chk("fill", 1, fill_out);
    level_reached = 1;
    repeat (3) @(negedge clk);
    chk("fill", 0, fill_out);
    other_req = 0;
    wait_for(4, 20);
    wait_for(1, 20);
    repeat (20) @(negedge clk);
    chk("remain lower", 1, remain_s < r);
    wait_for(2, 200);
    @(negedge clk);
    chk("motion", 0, motion_out);
    slow = 0;
    fill_req = 0;
    level_reached = 0;
  endtask
  task automatic t_coin;
    coin_mode = 1;
    other_req = 1;
    go(5'h00, 16'h0000, 16'h0003);
    repeat (20) @(negedge clk);
    chk("held", 0, timer_held);
    wait_for(2, 60);
    other_req = 0;
    coin_mode = 0;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    chk("chem", 0, chem_req);
    chk("busy", 0, step_busy);
    resetn = 1;
    t_each();
    t_glitch();
    t_hold();
    t_coin();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
endmodule
